// ==== hw/lamp_pkg.sv ====
package lamp_pkg;

  // Clock and time bases
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned SECOND_MS       = 1000;
  localparam int unsigned BLINK_PERIOD_MS = 1000;
  localparam int unsigned PAIR_WINDOW_MS  = 2000;
  localparam int unsigned SEC_CYCLES      = CLK_HZ / 1000 * SECOND_MS;
  localparam int unsigned BLINK_HALF_CYC  = CLK_HZ / 1000 * BLINK_PERIOD_MS / 2;
  localparam int unsigned PAIR_CYCLES     = CLK_HZ / 1000 * PAIR_WINDOW_MS;
  localparam logic [2:0]  BOOT_SETTLE     = 3'h3;

  // Maximum muting durations in seconds
  localparam logic [16:0] MUTE_1MIN_S  = 17'h0003C;
  localparam logic [16:0] MUTE_90MIN_S = 17'h01518;
  localparam logic [16:0] MUTE_24H_S   = 17'h15180;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFS    = 4'h0;
  localparam logic [3:0] STATUS_OFS  = 4'h4;
  localparam logic [3:0] ELAPSED_OFS = 4'h8;
  localparam logic [3:0] LAMPS_OFS   = 4'hC;

  // Field positions
  localparam int unsigned CTRL_VARIANT_BIT = 0;
  localparam int unsigned ST_MUTING_BIT    = 0;
  localparam int unsigned ST_ENABLE_BIT    = 1;
  localparam int unsigned ST_SELFAULT_BIT  = 2;
  localparam int unsigned ST_CFGDONE_BIT   = 3;
  localparam int unsigned ST_DUR_LSB       = 4;
  localparam logic        CTRL_VARIANT_RST = 1'b0;

  // Synchroniser lanes for pin inputs
  localparam int unsigned SYN_SEL_A = 0;
  localparam int unsigned SYN_SEL_B = 1;
  localparam int unsigned SYN_FAULT = 2;
  localparam int unsigned SYN_SNS_A = 3;
  localparam int unsigned SYN_SNS_B = 4;
  localparam int unsigned SYN_EN    = 5;
  localparam int unsigned SYN_BTN   = 6;
  localparam int unsigned SYN_W     = 7;

  typedef enum logic [1:0] {dur_1min, dur_90min, dur_24h} dur_t;
  typedef enum logic [1:0] {m_idle, m_pair, m_active, m_clear} mute_st_t;

  typedef struct packed {
    logic pwr_test_lamp;
    logic tx_fault_lamp;
    logic rx_fault_lamp;
    logic outputs_off_lamp;
    logic outputs_on_lamp;
    logic await_restart_lamp;
    logic align_bar_lamp_a;
    logic align_bar_lamp_b;
    logic align_bar_lamp_c;
    logic override_lamp;
    logic mute_enable_lamp;
    logic sensor_a_lamp;
    logic sensor_b_lamp;
    logic muting_active_lamp;
  } lamps_t;

endpackage

// ==== hw/muting_lamps.sv ====
// Chosen here: the register addresses and the Avalon-MM slave port.
module muting_lamps #(
  parameter int unsigned SEC_CYC   = lamp_pkg::SEC_CYCLES,     // Cycles per second
  parameter int unsigned BLINK_HALF = lamp_pkg::BLINK_HALF_CYC, // Cycles per blink half
  parameter int unsigned PAIR_CYC  = lamp_pkg::PAIR_CYCLES     // Sensor pairing window
) (
  input  wire logic            clock,            // System clock
  input  wire logic            rst,              // Synchronous reset, power-up
  input  wire logic [3:0]      address,          // Avalon byte address
  input  wire logic            read,             // Avalon read
  input  wire logic            write,            // Avalon write
  input  wire logic [3:0]      byteenable,       // Avalon byte lanes
  input  wire logic [31:0]     writedata,        // Avalon write data
  output logic [31:0]          readdata,         // Avalon read data
  output logic                 waitrequest,      // Avalon wait
  input  wire logic            time_sel_a,       // Pin, muting-time select one
  input  wire logic            time_sel_b,       // Pin, muting-time select two
  input  wire logic            time_sel_fault,   // Pin, selection wiring monitor
  input  wire logic            sensor_a,         // Pin, muting sensor one
  input  wire logic            sensor_b,         // Pin, muting sensor two
  input  wire logic            mute_enable_in,   // Pin, muting enable
  input  wire logic            restart_button,   // Pin, restart push button
  input  wire logic            safety_output_a,  // Safety output one state
  input  wire logic            safety_output_b,  // Safety output two state
  input  wire logic            tx_test_active,   // Transmitter test running
  input  wire logic            internal_fault,   // Curtain stopped on failure
  input  wire logic            manual_restart,   // Manual restart selected
  input  wire logic [7:0]      beams_aligned,    // Count of aligned beams
  input  wire logic [7:0]      beams_total,      // Count of beams
  input  wire logic            first_beam_cut,   // First beam interrupted
  input  wire logic            override_active,  // Guard override running
  input  wire logic            override_error,   // Guard override activation error
  output lamp_pkg::lamps_t     lamps,            // All indicator lamps
  output logic                 muting_active,    // Muting in progress
  output lamp_pkg::dur_t       max_duration      // Configured muting limit
);

  typedef struct packed {
    logic [lamp_pkg::SYN_W-1:0] sync1;
    logic [lamp_pkg::SYN_W-1:0] sync2;
    logic [2:0]                 boot_cnt;
    logic                       cfg_done;
    logic [1:0]                 sel_raw;
    logic                       sel_fault_seen;
    lamp_pkg::dur_t             dur;
    lamp_pkg::mute_st_t         mst;
    logic [31:0]                pair_cnt;
    logic [31:0]                sec_cnt;
    logic [16:0]                elapsed;
    logic [31:0]                blink_cnt;
    logic                       blink;
    logic                       outputs_on_d;
    logic                       bar_blank;
    logic                       btn_pressed;
    logic                       restarted;
    logic                       variant;
    logic                       ack;
    logic [31:0]                rdata;
    lamp_pkg::lamps_t           lamps;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Duration limit in seconds
  function automatic logic [16:0] limit_s(input lamp_pkg::dur_t d);
    case (d)
      lamp_pkg::dur_90min: limit_s = lamp_pkg::MUTE_90MIN_S;
      lamp_pkg::dur_24h:   limit_s = lamp_pkg::MUTE_24H_S;
      default:             limit_s = lamp_pkg::MUTE_1MIN_S;
    endcase
  endfunction

  function automatic lamp_pkg::dur_t decode_sel(input logic [1:0] s);
    case (s)
      2'h1:    decode_sel = lamp_pkg::dur_24h;
      2'h2:    decode_sel = lamp_pkg::dur_90min;
      default: decode_sel = lamp_pkg::dur_1min;
    endcase
  endfunction

  logic        outs_on;
  logic        outs_off;
  logic        sns_a;
  logic        sns_b;
  logic        mute_en;
  logic        btn;
  logic        all_aligned;
  logic [9:0]  aligned_x3;
  logic [9:0]  total_x1;
  logic [9:0]  total_x2;

  // Synchronised pin levels, unsynchronised safety output states and beam fractions
  // high means active
  assign sns_a       = st_ff.sync2[lamp_pkg::SYN_SNS_A];
  assign sns_b       = st_ff.sync2[lamp_pkg::SYN_SNS_B];
  assign mute_en     = st_ff.sync2[lamp_pkg::SYN_EN];
  assign btn         = st_ff.sync2[lamp_pkg::SYN_BTN];
  assign outs_on     = safety_output_a & safety_output_b;
  assign outs_off    = ~safety_output_a & ~safety_output_b;
  assign aligned_x3  = 10'({2'h0, beams_aligned} * 10'h003);
  assign total_x1    = {2'h0, beams_total};
  assign total_x2    = {1'h0, beams_total, 1'h0};
  assign all_aligned = (beams_aligned == beams_total) && (beams_total != 8'h00);

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1 = {restart_button, mute_enable_in, sensor_b, sensor_a,
                    time_sel_fault, time_sel_b, time_sel_a};
    nxt_st.sync2 = st_ff.sync1;

    // Power-up capture after synchronisers settle
    // capture once
    if (!st_ff.cfg_done) begin
      if (st_ff.boot_cnt == lamp_pkg::BOOT_SETTLE) begin
        nxt_st.cfg_done = 1'b1;
        nxt_st.sel_raw  = {st_ff.sync2[lamp_pkg::SYN_SEL_A], st_ff.sync2[lamp_pkg::SYN_SEL_B]};
        nxt_st.dur      = decode_sel({st_ff.sync2[lamp_pkg::SYN_SEL_A],
                                      st_ff.sync2[lamp_pkg::SYN_SEL_B]});
      end else begin
        nxt_st.boot_cnt = 3'(st_ff.boot_cnt + 3'h1);
      end
    end
    if (st_ff.cfg_done && st_ff.sync2[lamp_pkg::SYN_FAULT]) begin
      nxt_st.sel_fault_seen = 1'b1;
    end
    if (nxt_st.sel_fault_seen) begin
      nxt_st.dur = lamp_pkg::dur_1min;
    end

    // Blink generator, equal halves
    // one-second period
    if (st_ff.blink_cnt >= BLINK_HALF - 1) begin
      nxt_st.blink_cnt = 32'h0;
      nxt_st.blink     = ~st_ff.blink;
    end else begin
      nxt_st.blink_cnt = st_ff.blink_cnt + 32'h1;
    end

    // Muting sequencer
    // pairing, drop and limit
    case (st_ff.mst)
      lamp_pkg::m_idle: begin
        nxt_st.pair_cnt = 32'h0;
        nxt_st.sec_cnt  = 32'h0;
        nxt_st.elapsed  = 17'h0;
        if (st_ff.cfg_done && mute_en) begin
          if (sns_a && sns_b) begin
            nxt_st.mst = lamp_pkg::m_active;
          end else if (sns_a || sns_b) begin
            nxt_st.mst = lamp_pkg::m_pair;
          end
        end
      end
      lamp_pkg::m_pair: begin
        nxt_st.pair_cnt = st_ff.pair_cnt + 32'h1;
        if (!mute_en) begin
          nxt_st.mst = lamp_pkg::m_clear;
        end else if (sns_a && sns_b) begin
          nxt_st.mst = lamp_pkg::m_active;
        end else if (!sns_a && !sns_b) begin
          nxt_st.mst = lamp_pkg::m_idle;
        end else if (st_ff.pair_cnt >= PAIR_CYC - 1) begin
          nxt_st.mst = lamp_pkg::m_clear;
        end
      end
      lamp_pkg::m_active: begin
        if (st_ff.sec_cnt >= SEC_CYC - 1) begin
          nxt_st.sec_cnt = 32'h0;
          nxt_st.elapsed = 17'(st_ff.elapsed + 17'h1);
        end else begin
          nxt_st.sec_cnt = st_ff.sec_cnt + 32'h1;
        end
        if (!mute_en || !sns_a || !sns_b || nxt_st.elapsed >= limit_s(nxt_st.dur)) begin
          nxt_st.mst = lamp_pkg::m_clear;
        end
      end
      lamp_pkg::m_clear: begin
        if (!sns_a && !sns_b) begin
          nxt_st.mst = lamp_pkg::m_idle;
        end
      end
      default: nxt_st.mst = lamp_pkg::m_idle;
    endcase

    // Bargraph blanking on outputs switching on
    // blank on rising outputs
    nxt_st.outputs_on_d = outs_on;
    if (outs_on && !st_ff.outputs_on_d) begin
      nxt_st.bar_blank = 1'b1;
    end else if (!outs_on) begin
      nxt_st.bar_blank = 1'b0;
    end

    // Restart button press-then-release tracking
    // press then release
    if (!all_aligned || outs_on || !manual_restart) begin
      nxt_st.restarted   = 1'b0;
      nxt_st.btn_pressed = 1'b0;
    end else if (btn) begin
      nxt_st.btn_pressed = 1'b1;
    end else if (st_ff.btn_pressed) begin
      nxt_st.restarted   = 1'b1;
      nxt_st.btn_pressed = 1'b0;
    end

    // Lamp outputs
    // power and test
    nxt_st.lamps.pwr_test_lamp = tx_test_active ? st_ff.blink : 1'b1;
    nxt_st.lamps.tx_fault_lamp = internal_fault;
    nxt_st.lamps.rx_fault_lamp = internal_fault;
    nxt_st.lamps.outputs_off_lamp = outs_off;
    nxt_st.lamps.outputs_on_lamp = outs_on;
    nxt_st.lamps.await_restart_lamp = manual_restart && all_aligned && !outs_on
                                      && !nxt_st.restarted;
    if (nxt_st.bar_blank || beams_aligned == 8'h00 || first_beam_cut) begin
      nxt_st.lamps.align_bar_lamp_a = 1'b0;
      nxt_st.lamps.align_bar_lamp_b = 1'b0;
      nxt_st.lamps.align_bar_lamp_c = 1'b0;
    end else if (aligned_x3 < total_x1) begin
      nxt_st.lamps.align_bar_lamp_a = st_ff.blink;
      nxt_st.lamps.align_bar_lamp_b = 1'b0;
      nxt_st.lamps.align_bar_lamp_c = 1'b0;
    end else if (aligned_x3 < total_x2) begin
      nxt_st.lamps.align_bar_lamp_a = 1'b1;
      nxt_st.lamps.align_bar_lamp_b = st_ff.blink;
      nxt_st.lamps.align_bar_lamp_c = 1'b0;
    end else if (!all_aligned) begin
      nxt_st.lamps.align_bar_lamp_a = 1'b1;
      nxt_st.lamps.align_bar_lamp_b = 1'b1;
      nxt_st.lamps.align_bar_lamp_c = st_ff.blink;
    end else begin
      nxt_st.lamps.align_bar_lamp_a = 1'b1;
      nxt_st.lamps.align_bar_lamp_b = 1'b1;
      nxt_st.lamps.align_bar_lamp_c = 1'b1;
    end
    nxt_st.lamps.override_lamp = override_error ? st_ff.blink : override_active;
    nxt_st.lamps.mute_enable_lamp = mute_en;
    if (st_ff.variant) begin
      case (st_ff.dur)
        lamp_pkg::dur_24h:   {nxt_st.lamps.sensor_a_lamp, nxt_st.lamps.sensor_b_lamp} = 2'h1;
        lamp_pkg::dur_90min: {nxt_st.lamps.sensor_a_lamp, nxt_st.lamps.sensor_b_lamp} = 2'h2;
        default:             {nxt_st.lamps.sensor_a_lamp, nxt_st.lamps.sensor_b_lamp} = 2'h3;
      endcase
    end else begin
      nxt_st.lamps.sensor_a_lamp = sns_a;
      nxt_st.lamps.sensor_b_lamp = sns_b;
    end
    nxt_st.lamps.muting_active_lamp = (st_ff.mst == lamp_pkg::m_active);

    // Avalon slave, one wait cycle per access
    nxt_st.ack = (read || write) && !st_ff.ack;
    if ((read || write) && !st_ff.ack) begin
      case (address)
        lamp_pkg::CTRL_OFS:    nxt_st.rdata = {31'h0, st_ff.variant};
        lamp_pkg::STATUS_OFS:  nxt_st.rdata = {26'h0, st_ff.dur, st_ff.cfg_done,
                                              st_ff.sel_fault_seen, mute_en,
                                              st_ff.mst == lamp_pkg::m_active};
        lamp_pkg::ELAPSED_OFS: nxt_st.rdata = {15'h0, st_ff.elapsed};
        lamp_pkg::LAMPS_OFS:   nxt_st.rdata = {18'h0, st_ff.lamps};
        default:               nxt_st.rdata = 32'h0;
      endcase
    end
    if (write && st_ff.ack && address == lamp_pkg::CTRL_OFS && byteenable[0]) begin
      nxt_st.variant = writedata[lamp_pkg::CTRL_VARIANT_BIT];
    end

    // Power-up state
    if (rst) begin
      nxt_st                = '0;
      nxt_st.variant        = lamp_pkg::CTRL_VARIANT_RST;
      nxt_st.dur            = lamp_pkg::dur_1min;
      nxt_st.mst            = lamp_pkg::m_idle;
      nxt_st.lamps.pwr_test_lamp = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register and outputs

  always_ff @(posedge clock) begin
    st_ff <= nxt_st;
  end

  assign lamps         = st_ff.lamps;
  assign muting_active = (st_ff.mst == lamp_pkg::m_active);
  assign max_duration  = st_ff.dur;
  assign readdata      = st_ff.rdata;
  assign waitrequest   = (read || write) && !st_ff.ack;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  cfg_hold_a: assert property (
    st_ff.cfg_done && $past(st_ff.cfg_done) |-> $stable(st_ff.sel_raw)
  ) else $error("selection changed after capture");

  decode_a: assert property (
    st_ff.cfg_done && !st_ff.sel_fault_seen |-> st_ff.dur == decode_sel(st_ff.sel_raw)
  ) else $error("duration decode mismatch");

  fault_dur_a: assert property (
    st_ff.cfg_done && st_ff.sync2[lamp_pkg::SYN_FAULT] |=> st_ff.dur == lamp_pkg::dur_1min
  ) else $error("fault did not force minimum duration");

  pwr_lamp_a: assert property (
    !tx_test_active |=> st_ff.lamps.pwr_test_lamp
  ) else $error("power lamp dark without test");

  fault_lamp_a: assert property (
    internal_fault |=> st_ff.lamps.tx_fault_lamp && st_ff.lamps.rx_fault_lamp
  ) else $error("fault lamps dark on failure");

  outs_off_a: assert property (
    !rst && !safety_output_a && !safety_output_b |=> st_ff.lamps.outputs_off_lamp
                                            && !st_ff.lamps.outputs_on_lamp
  ) else $error("outputs-off lamp wrong");

  outs_on_a: assert property (
    !rst && safety_output_a && safety_output_b |=> st_ff.lamps.outputs_on_lamp
                                          && !st_ff.lamps.outputs_off_lamp
  ) else $error("outputs-on lamp wrong");

  blink_half_a: assert property (
    $changed(st_ff.blink) |-> $past(st_ff.blink_cnt) == BLINK_HALF - 1
  ) else $error("blink toggled off schedule");

  bar_blank_a: assert property (
    outs_on && !st_ff.outputs_on_d ##1 outs_on |=> !st_ff.lamps.align_bar_lamp_a
      && !st_ff.lamps.align_bar_lamp_b && !st_ff.lamps.align_bar_lamp_c
  ) else $error("bargraph lit after outputs on");

  mute_drop_a: assert property (
    st_ff.mst == lamp_pkg::m_active && !(sns_a && sns_b) |=> st_ff.mst != lamp_pkg::m_active
  ) else $error("muting held after sensor drop");

  mute_enable_a: assert property (
    !mute_en |=> st_ff.mst != lamp_pkg::m_active
  ) else $error("muting active while disabled");

  mute_limit_a: assert property (
    st_ff.mst == lamp_pkg::m_active |-> st_ff.elapsed < limit_s(st_ff.dur)
  ) else $error("muting exceeded limit");

  sensor_lamp_a: assert property (
    !st_ff.variant |=> st_ff.lamps.sensor_a_lamp == $past(sns_a)
                      && st_ff.lamps.sensor_b_lamp == $past(sns_b)
  ) else $error("sensor lamps do not follow sensors");

  mute_lamp_a: assert property (
    ##1 st_ff.lamps.muting_active_lamp == $past(st_ff.mst == lamp_pkg::m_active)
  ) else $error("muting lamp mismatch");

  mute_c:   cover property (st_ff.mst == lamp_pkg::m_pair ##1 st_ff.mst == lamp_pkg::m_active);
  expire_c: cover property (st_ff.mst == lamp_pkg::m_pair ##1 st_ff.mst == lamp_pkg::m_clear);
  cover_fault_c: cover property ($rose(st_ff.sel_fault_seen));
  cover_blank_c: cover property ($rose(st_ff.bar_blank));

endmodule // muting_lamps

// ==== verification/muting_far_side.sv ====
module muting_far_side (
  input  wire logic       clock,           // System clock
  input  wire logic       want_a,          // Bench wants sensor one active
  input  wire logic       want_b,          // Bench wants sensor two active
  input  wire logic [1:0] sel,             // Selection wires, first in msb
  input  wire logic       wire_cut,        // Broken selection wiring
  output logic            sensor_a,        // Muting sensor one pin
  output logic            sensor_b,        // Muting sensor two pin
  output logic            time_sel_a,      // Selection wire one pin
  output logic            time_sel_b,      // Selection wire two pin
  output logic            time_sel_fault   // Wiring monitor pin
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock) begin
    sensor_a <= want_a;
    sensor_b <= want_b;
  end
  // Selection wires and their monitor
  assign time_sel_a     = sel[1];
  assign time_sel_b     = sel[0];
  assign time_sel_fault = wire_cut;
endmodule // muting_far_side

// ==== verification/tb_muting_lamps.sv ====
module tb_muting_lamps;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 10;
  localparam int BH = 4;
  localparam int PC = 20;
  logic clock = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
  logic [3:0] address = 4'h0, byteenable = 4'hF;
  logic [31:0] writedata = 32'h0, readdata;
  logic waitrequest, muting_active, sensor_a, sensor_b, time_sel_a, time_sel_b, time_sel_fault;
  logic want_a = 1'b0, want_b = 1'b0, wire_cut = 1'b0, mute_enable_in = 1'b1;
  logic [1:0] sel = 2'h0;
  logic restart_button = 1'b0, safety_output_a = 1'b0, safety_output_b = 1'b0;
  logic tx_test_active = 1'b0, internal_fault = 1'b0, manual_restart = 1'b0;
  logic [7:0] beams_aligned = 8'h1E, beams_total = 8'h1E;
  logic first_beam_cut = 1'b0, override_active = 1'b0, override_error = 1'b0;
  lamp_pkg::lamps_t lamps;
  lamp_pkg::dur_t max_duration;
  int checks = 0, bad_count = 0, cyc = 0;

  muting_lamps #(.SEC_CYC(SC), .BLINK_HALF(BH), .PAIR_CYC(PC)) muting_lamps_inst (
    .clock, .rst, .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest,
    .time_sel_a, .time_sel_b, .time_sel_fault, .sensor_a, .sensor_b, .mute_enable_in,
    .restart_button, .safety_output_a, .safety_output_b, .tx_test_active, .internal_fault,
    .manual_restart, .beams_aligned, .beams_total, .first_beam_cut, .override_active,
    .override_error, .lamps, .muting_active, .max_duration);
  muting_far_side muting_far_side_inst (.clock, .want_a, .want_b, .sel, .wire_cut,
    .sensor_a, .sensor_b, .time_sel_a, .time_sel_b, .time_sel_fault);

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers; outputs read right after an edge hold their settled value
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Avalon access held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) bad_count++;
  endtask
  task automatic reboot(input logic [1:0] s, input logic cut);
    sel <= s;
    wire_cut <= cut;
    rst <= 1'b1;
    w(16);
    rst <= 1'b0;
    w(12);
  endtask
  task automatic pair_on;
    int n;
    want_a <= 1'b1;
    w(3);
    want_b <= 1'b1;
    n = 0;
    do begin
      w(1);
      n++;
    end while (muting_active !== 1'b1 && n < 12);
    chk(muting_active, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_config;
    logic [31:0] q;
    reboot(2'h2, 1'b0);
    chk(max_duration, lamp_pkg::dur_90min);
    sel <= 2'h1;
    w(12);
    chk(max_duration, lamp_pkg::dur_90min);
    bus(1'b0, lamp_pkg::STATUS_OFS, 32'h0, q);
    chk(q[5:3], 3'h3);
    bus(1'b1, lamp_pkg::CTRL_OFS, 32'h1, q);
    w(4);
    chk({lamps.sensor_a_lamp, lamps.sensor_b_lamp}, 2'h2);
    bus(1'b0, 4'h2, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b1, lamp_pkg::CTRL_OFS, 32'h0, q);
    $display("config test done");
  endtask
  task automatic t_mute;
    pair_on();
    w(2);
    chk(lamps[3:0], 4'hF);
    want_a <= 1'b0;
    w(8);
    chk({muting_active, lamps[3:0]}, 5'h0A);
    want_b <= 1'b0;
    w(8);
    want_a <= 1'b1;
    w(PC + 10);
    want_b <= 1'b1;
    w(12);
    chk(muting_active, 1'b0);
    want_a <= 1'b0;
    want_b <= 1'b0;
    mute_enable_in <= 1'b0;
    w(8);
    want_a <= 1'b1;
    want_b <= 1'b1;
    w(12);
    chk(lamps[3:0], 4'h6);
    want_a <= 1'b0;
    want_b <= 1'b0;
    mute_enable_in <= 1'b1;
    w(8);
    $display("muting test done");
  endtask
  task automatic t_lamps;
    w(3);
    chk({lamps.pwr_test_lamp, lamps.outputs_off_lamp, lamps[7:5]}, 5'h1F);
    safety_output_a <= 1'b1;
    safety_output_b <= 1'b1;
    w(3);
    chk({lamps.outputs_on_lamp, lamps.outputs_off_lamp, lamps[7:5]}, 5'h10);
    safety_output_a <= 1'b0;
    safety_output_b <= 1'b0;
    beams_aligned <= 8'h00;
    internal_fault <= 1'b1;
    override_active <= 1'b1;
    w(3);
    chk({lamps.tx_fault_lamp, lamps.rx_fault_lamp, lamps.override_lamp, lamps[7:5]},
        6'h38);
    internal_fault <= 1'b0;
    override_active <= 1'b0;
    manual_restart <= 1'b1;
    beams_aligned <= 8'h1E;
    w(3);
    chk({lamps.await_restart_lamp, lamps.override_lamp}, 2'h2);
    restart_button <= 1'b1;
    w(6);
    restart_button <= 1'b0;
    w(6);
    chk(lamps.await_restart_lamp, 1'b0);
    manual_restart <= 1'b0;
    $display("lamp test done");
  endtask
  // Three bargraph bands, with override error blinking over an active override
  task automatic t_blink;
    int hp, ha, hb, hc, ho, tg, k;
    logic prev;
    tx_test_active <= 1'b1;
    override_active <= 1'b1;
    override_error <= 1'b1;
    for (k = 0; k < 3; k++) begin
      beams_aligned <= (k == 0) ? 8'h05 : ((k == 1) ? 8'h0F : 8'h19);
      hp = 0;
      ha = 0;
      hb = 0;
      hc = 0;
      ho = 0;
      tg = 0;
      w(4);
      prev = lamps.pwr_test_lamp;
      repeat (4 * BH) begin
        w(1);
        hp += lamps.pwr_test_lamp;
        ha += lamps.align_bar_lamp_a;
        hb += lamps.align_bar_lamp_b;
        hc += lamps.align_bar_lamp_c;
        ho += lamps.override_lamp;
        tg += (lamps.pwr_test_lamp !== prev);
        prev = lamps.pwr_test_lamp;
      end
      chk(hp, 2 * BH);
      chk(tg, 4);
      chk(ho, 2 * BH);
      chk(ha, (k == 0) ? 2 * BH : 4 * BH);
      chk(hb, (k == 0) ? 0 : ((k == 1) ? 2 * BH : 4 * BH));
      chk(hc, (k == 2) ? 2 * BH : 0);
    end
    first_beam_cut <= 1'b1;
    w(3);
    chk(lamps[7:5], 3'h0);
    first_beam_cut <= 1'b0;
    tx_test_active <= 1'b0;
    override_active <= 1'b0;
    override_error <= 1'b0;
    $display("blink test done");
  endtask
  task automatic t_limit;
    logic [31:0] q;
    reboot(2'h1, 1'b1);
    chk(max_duration, lamp_pkg::dur_1min);
    pair_on();
    w(560);
    chk(muting_active, 1'b1);
    w(60);
    chk(muting_active, 1'b0);
    bus(1'b0, lamp_pkg::ELAPSED_OFS, 32'h0, q);
    chk(q, 32'(lamp_pkg::MUTE_1MIN_S));
    $display("limit test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic results;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    t_config();
    t_mute();
    t_lamps();
    t_blink();
    t_limit();
    results();
  end
endmodule // tb_muting_lamps
